// ### rtl/cpu_core_map.svh
// Offsets, field positions, reset values and timing counts of the core.
// Assumes it is included by bare name from files under rtl/.
`ifndef CPU_CORE_MAP_SVH
`define CPU_CORE_MAP_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PHASES_PER_CYCLE 4
`define REF_OSC_MHZ 10
`define REF_INSTR_NS 400
`define REF_CLOCK_NS (1000 / `REF_OSC_MHZ)
`define INSTR_CYCLE_CLOCKS (`REF_INSTR_NS / `REF_CLOCK_NS)

// ----------------------------------------------------------------------
// Memories and vectors
// ----------------------------------------------------------------------
`define PMEM_DEPTH 1024
`define PMEM_AW 10
`define DMEM_DEPTH 128
`define RESET_VECTOR 13'h0000
`define IRQ_VECTOR 13'h0004

// ----------------------------------------------------------------------
// Special function register addresses
// ----------------------------------------------------------------------
`define ADDR_INDIRECT 7'h00
`define ADDR_IP_LOW 7'h02
`define ADDR_STATUS 7'h03
`define ADDR_FSR 7'h04
`define ADDR_IP_LATCH 7'h0A

// ----------------------------------------------------------------------
// Status fields and reset values
// ----------------------------------------------------------------------
`define ST_CARRY 0
`define ST_DIGIT 1
`define ST_ZERO 2
`define STATUS_RESET 8'h18
`define STATUS_FIXED_MASK 8'h18

`endif

// ### rtl/cpu_core_pkg.sv
// Types shared by the core sequencing, the phase generator and the ALU.
// Assumes cpu_core_map.svh holds all numeric constants.
package cpu_core_pkg;

  typedef enum logic [1:0] {
    phase_1,
    phase_2,
    phase_3,
    phase_4
  } phase_e;

  typedef enum logic [3:0] {
    alu_add,
    alu_sub,
    alu_and,
    alu_or,
    alu_xor,
    alu_com,
    alu_inc,
    alu_dec,
    alu_rlf,
    alu_rrf,
    alu_swap,
    alu_pass_b,
    alu_pass_a,
    alu_clr
  } alu_op_e;

  typedef struct packed {
    logic [7:0] result;
    logic carry;
    logic digit;
    logic zero;
  } alu_out_s;

  typedef struct packed {
    alu_op_e op;
    logic use_literal;
    logic bit_op;
    logic dest_w;
    logic dest_f;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic is_goto;
  } decode_s;

  typedef struct packed {
    logic [12:0] ip;
    logic [12:0] fetch_addr;
    logic [13:0] fetch_word;
    logic fetch_valid;
    logic [13:0] ir;
    logic ir_valid;
    logic [7:0] operand;
    logic [7:0] w;
    logic [7:0] status;
    logic [7:0] fsr;
    logic [4:0] ip_latch;
    logic irq_pending;
    logic clkout;
  } core_state_s;

  typedef struct packed {
    phase_e phase;
  } phase_state_s;

endpackage

// ### rtl/phase_gen.sv
// Divides the input clock into four quadrature phases.
// Assumes clock is the oscillator and clear is synchronous to it.
`timescale 1ns/10ps
`default_nettype none

module phase_gen (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  output cpu_core_pkg::phase_e phase
);

  cpu_core_pkg::phase_state_s state_reg;
  cpu_core_pkg::phase_state_s state_next;

  always_comb begin
    state_next = state_reg;
    if (clear) begin
      state_next.phase = cpu_core_pkg::phase_1;
    end else begin
      case (state_reg.phase)
        cpu_core_pkg::phase_1: state_next.phase = cpu_core_pkg::phase_2;
        cpu_core_pkg::phase_2: state_next.phase = cpu_core_pkg::phase_3;
        cpu_core_pkg::phase_3: state_next.phase = cpu_core_pkg::phase_4;
        default: state_next.phase = cpu_core_pkg::phase_1;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg.phase <= cpu_core_pkg::phase_1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign phase = state_reg.phase;

endmodule

`default_nettype wire

// ### rtl/core_alu.sv
// Eight-bit combinational ALU with carry, digit carry and zero outputs.
// Assumes the caller chooses which flags it keeps.
`timescale 1ns/10ps
`default_nettype none

module core_alu (
  input wire cpu_core_pkg::alu_op_e op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  output cpu_core_pkg::alu_out_s out
);

  logic [8:0] sum;
  logic [4:0] low;

  always_comb begin
    sum = 9'h000;
    low = 5'h00;
    out.result = 8'h00;
    out.carry = carry_in;
    out.digit = 1'b0;
    case (op)
      cpu_core_pkg::alu_add: begin
        sum = {1'b0, b} + {1'b0, a};
        low = {1'b0, b[3:0]} + {1'b0, a[3:0]};
        out.result = sum[7:0];
        out.carry = sum[8];
        out.digit = low[4];
      end
      cpu_core_pkg::alu_sub: begin
        // Two's complement: b + ~a + 1, so carry set means no borrow.
        sum = {1'b0, b} + {1'b0, ~a} + 9'h001;
        low = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
        out.result = sum[7:0];
        out.carry = sum[8];
        out.digit = low[4];
      end
      cpu_core_pkg::alu_and: out.result = a & b;
      cpu_core_pkg::alu_or: out.result = a | b;
      cpu_core_pkg::alu_xor: out.result = a ^ b;
      cpu_core_pkg::alu_com: out.result = ~b;
      cpu_core_pkg::alu_inc: out.result = b + 8'h01;
      cpu_core_pkg::alu_dec: out.result = b - 8'h01;
      cpu_core_pkg::alu_rlf: begin
        out.result = {b[6:0], carry_in};
        out.carry = b[7];
      end
      cpu_core_pkg::alu_rrf: begin
        out.result = {carry_in, b[7:1]};
        out.carry = b[0];
      end
      cpu_core_pkg::alu_swap: out.result = {b[3:0], b[7:4]};
      cpu_core_pkg::alu_pass_b: out.result = b;
      cpu_core_pkg::alu_pass_a: out.result = a;
      default: out.result = 8'h00;
    endcase
    out.zero = (out.result == 8'h00);
  end

endmodule

`default_nettype wire

// ### rtl/cpu_core.sv
// Core sequencing: phase timing, two-stage fetch/execute pipeline,
// program and data memories, working accumulator and status flags.
// Assumes clock is the oscillator input and all inputs are synchronous.
`include "cpu_core_map.svh"
`timescale 1ns/10ps
`default_nettype none

module cpu_core (
  input wire logic clock,
  input wire logic rst,
  input wire logic master_clear_n,
  input wire logic rc_mode,
  input wire logic irq_request,
  input wire logic pmem_load_en,
  input wire logic [`PMEM_AW-1:0] pmem_load_addr,
  input wire logic [13:0] pmem_load_data,
  output logic clock_output_pin,
  output logic [12:0] instr_pointer,
  output cpu_core_pkg::phase_e phase,
  output logic [7:0] working_accumulator,
  output logic [7:0] status_out,
  output logic exec_valid
);

  // ----------------------------------------------------------------------
  // Memories
  // ----------------------------------------------------------------------
  logic [13:0] pmem [0:`PMEM_DEPTH-1];
  logic [7:0] dmem [0:`DMEM_DEPTH-1];

  cpu_core_pkg::core_state_s state_reg;
  cpu_core_pkg::core_state_s state_next;
  cpu_core_pkg::decode_s dec;
  cpu_core_pkg::alu_out_s alu_out;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] bit_mask;
  logic [6:0] file_addr;
  logic dmem_we;
  logic [7:0] write_data;
  logic clear;
  logic branch;

  assign clear = ~master_clear_n;

  // Indirect access goes through the file select register.
  function automatic logic [6:0] effective_addr(input logic [13:0] word, input logic [7:0] fsr);
    if (word[6:0] == `ADDR_INDIRECT) begin
      return fsr[6:0];
    end else begin
      return word[6:0];
    end
  endfunction

  function automatic cpu_core_pkg::decode_s decode(input logic [13:0] word);
    cpu_core_pkg::decode_s d;
    d = '{op: cpu_core_pkg::alu_pass_b, default: 1'b0};
    if (word[13:12] == 2'b00) begin
      d.dest_w = ~word[7];
      d.dest_f = word[7];
      d.upd_z = 1'b1;
      case (word[11:8])
        4'h0: begin
          d.op = cpu_core_pkg::alu_pass_a;
          d.upd_z = 1'b0;
          d.dest_w = 1'b0;
        end
        4'h1: d.op = cpu_core_pkg::alu_clr;
        4'h2: begin
          d.op = cpu_core_pkg::alu_sub;
          {d.upd_c, d.upd_dc} = 2'b11;
        end
        4'h3: d.op = cpu_core_pkg::alu_dec;
        4'h4: d.op = cpu_core_pkg::alu_or;
        4'h5: d.op = cpu_core_pkg::alu_and;
        4'h6: d.op = cpu_core_pkg::alu_xor;
        4'h7: begin
          d.op = cpu_core_pkg::alu_add;
          {d.upd_c, d.upd_dc} = 2'b11;
        end
        4'h8: d.op = cpu_core_pkg::alu_pass_b;
        4'h9: d.op = cpu_core_pkg::alu_com;
        4'hA: d.op = cpu_core_pkg::alu_inc;
        4'hC: begin
          d.op = cpu_core_pkg::alu_rrf;
          {d.upd_c, d.upd_z} = 2'b10;
        end
        4'hD: begin
          d.op = cpu_core_pkg::alu_rlf;
          {d.upd_c, d.upd_z} = 2'b10;
        end
        4'hE: begin
          d.op = cpu_core_pkg::alu_swap;
          d.upd_z = 1'b0;
        end
        default: begin
          {d.dest_w, d.dest_f, d.upd_z} = 3'b000;
        end
      endcase
      // Clearing the accumulator form has bit 7 low and writes zero to it.
      if (word[11:7] == 5'b00010) begin
        d.dest_w = 1'b1;
      end
      // Moving the accumulator out with bit 7 low is the no-operation form.
      if (word[11:8] == 4'h0 && !word[7]) begin
        d.dest_f = 1'b0;
      end
    end else if (word[13:12] == 2'b01) begin
      d.bit_op = ~word[11];
      d.dest_f = ~word[11];
      d.op = word[10] ? cpu_core_pkg::alu_or : cpu_core_pkg::alu_and;
    end else if (word[13:12] == 2'b10) begin
      d.is_goto = word[11];
    end else begin
      d.use_literal = 1'b1;
      d.dest_w = 1'b1;
      {d.upd_c, d.upd_dc, d.upd_z} = 3'b001;
      if (word[11:10] == 2'b00) begin
        d.upd_z = 1'b0;
      end else if (word[11:9] == 3'b111) begin
        d.op = cpu_core_pkg::alu_add;
        {d.upd_c, d.upd_dc} = 2'b11;
      end else if (word[11:9] == 3'b110) begin
        d.op = cpu_core_pkg::alu_sub;
        {d.upd_c, d.upd_dc} = 2'b11;
      end else if (word[11:8] == 4'h9) begin
        d.op = cpu_core_pkg::alu_and;
      end else if (word[11:8] == 4'h8) begin
        d.op = cpu_core_pkg::alu_or;
      end else if (word[11:8] == 4'hA) begin
        d.op = cpu_core_pkg::alu_xor;
      end else begin
        {d.dest_w, d.upd_z} = 2'b00;
      end
    end
    return d;
  endfunction

  // ----------------------------------------------------------------------
  // Phase generator and ALU
  // ----------------------------------------------------------------------
  phase_gen u_phase (
    .clock(clock),
    .rst(rst),
    .clear(clear),
    .phase(phase)
  );

  core_alu u_alu (
    .op(dec.op),
    .a(alu_a),
    .b(alu_b),
    .carry_in(state_reg.status[`ST_CARRY]),
    .out(alu_out)
  );

  // ----------------------------------------------------------------------
  // Datapath selection
  // ----------------------------------------------------------------------
  always_comb begin
    dec = decode(state_reg.ir);
    file_addr = effective_addr(state_reg.ir, state_reg.fsr);
    bit_mask = 8'h01 << state_reg.ir[9:7];
    if (dec.bit_op) begin
      alu_a = state_reg.ir[10] ? bit_mask : ~bit_mask;
    end else begin
      alu_a = state_reg.w;
    end
    alu_b = dec.use_literal ? state_reg.ir[7:0] : state_reg.operand;
  end

  assign write_data = alu_out.result;

  // ----------------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    branch = 1'b0;
    dmem_we = 1'b0;
    state_next.irq_pending = state_reg.irq_pending | irq_request;
    state_next.clkout = rc_mode && (phase == cpu_core_pkg::phase_2 || phase == cpu_core_pkg::phase_3);
    case (phase)
      cpu_core_pkg::phase_1: begin
        state_next.fetch_addr = state_reg.ip;
        state_next.ip = state_reg.ip + 13'h0001;
        state_next.ir = state_reg.fetch_word;
        state_next.ir_valid = state_reg.fetch_valid;
      end
      cpu_core_pkg::phase_2: begin
        if (file_addr == `ADDR_IP_LOW) begin
          state_next.operand = state_reg.ip[7:0];
        end else if (file_addr == `ADDR_STATUS) begin
          state_next.operand = state_reg.status;
        end else if (file_addr == `ADDR_FSR) begin
          state_next.operand = state_reg.fsr;
        end else if (file_addr == `ADDR_IP_LATCH) begin
          state_next.operand = {3'b000, state_reg.ip_latch};
        end else if (file_addr == `ADDR_INDIRECT) begin
          state_next.operand = 8'h00;
        end else begin
          state_next.operand = dmem[file_addr];
        end
      end
      cpu_core_pkg::phase_3: begin
        state_next.operand = state_reg.operand;
      end
      default: begin
        // Program bus read is 14 bits wide, upper pointer bits ignored.
        state_next.fetch_word = pmem[state_reg.fetch_addr[`PMEM_AW-1:0]];
        state_next.fetch_valid = 1'b1;
        if (state_reg.ir_valid) begin
          if (dec.upd_c) begin
            state_next.status[`ST_CARRY] = alu_out.carry;
          end
          if (dec.upd_dc) begin
            state_next.status[`ST_DIGIT] = alu_out.digit;
          end
          if (dec.upd_z) begin
            state_next.status[`ST_ZERO] = alu_out.zero;
          end
          if (dec.dest_w) begin
            state_next.w = write_data;
          end
          if (dec.is_goto) begin
            state_next.ip = {state_reg.ip_latch[4:3], state_reg.ir[10:0]};
            branch = 1'b1;
          end
          if (dec.dest_f) begin
            if (file_addr == `ADDR_IP_LOW) begin
              state_next.ip = {state_reg.ip_latch, write_data};
              branch = 1'b1;
            end else if (file_addr == `ADDR_STATUS) begin
              // Flags the instruction itself sets are not overwritten, and the
              // reset-status bits never take a write.
              state_next.status[7:5] = write_data[7:5];
              if (!dec.upd_c) begin
                state_next.status[`ST_CARRY] = write_data[`ST_CARRY];
              end
              if (!dec.upd_dc) begin
                state_next.status[`ST_DIGIT] = write_data[`ST_DIGIT];
              end
              if (!dec.upd_z) begin
                state_next.status[`ST_ZERO] = write_data[`ST_ZERO];
              end
            end else if (file_addr == `ADDR_FSR) begin
              state_next.fsr = write_data;
            end else if (file_addr == `ADDR_IP_LATCH) begin
              state_next.ip_latch = write_data[4:0];
            end else if (file_addr != `ADDR_INDIRECT) begin
              dmem_we = 1'b1;
            end
          end
        end
        if (!branch && state_reg.irq_pending) begin
          state_next.ip = `IRQ_VECTOR;
          state_next.irq_pending = irq_request;
          branch = 1'b1;
        end
        if (branch) begin
          // The word fetched alongside this execute is dropped, so the
          // target is fetched next and the branch costs two cycles.
          state_next.fetch_valid = 1'b0;
        end
        // Without a branch one instruction retires here every cycle.
      end
    endcase
    if (clear) begin
      state_next = '0;
      state_next.ip = `RESET_VECTOR;
      state_next.status = `STATUS_RESET;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.ip <= `RESET_VECTOR;
      state_reg.status <= `STATUS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Memories take no reset; their content is loaded or written by code.
  always_ff @(posedge clock) begin
    if (pmem_load_en) begin
      pmem[pmem_load_addr] <= pmem_load_data;
    end
    if (dmem_we && !clear) begin
      dmem[file_addr] <= write_data;
    end
  end

  assign clock_output_pin = state_reg.clkout;
  assign instr_pointer = state_reg.ip;
  assign working_accumulator = state_reg.w;
  assign status_out = state_reg.status;
  assign exec_valid = state_reg.ir_valid;

endmodule

`default_nettype wire

// ### verification/cpu_core_checker.sv
// Concurrent checks on the ports of the core.
// Assumes it is bound to cpu_core and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none

module cpu_core_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic master_clear_n,
  input wire logic rc_mode,
  input wire logic clock_output_pin,
  input wire logic [12:0] instr_pointer,
  input wire cpu_core_pkg::phase_e phase,
  input wire logic [7:0] working_accumulator,
  input wire logic [7:0] status_out,
  input wire logic exec_valid
);
  // Two edges after any reset are skipped, as $past still sees reset state there.
  logic [1:0] fresh_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fresh_reg <= 2'h3;
    end else begin
      fresh_reg <= {fresh_reg[0], !master_clear_n};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !master_clear_n || (|fresh_reg));
  property p_phase_seq;
    phase == cpu_core_pkg::phase_e'($past(phase) + 2'h1);
  endproperty
  property p_ip_step;
    phase == cpu_core_pkg::phase_1 |=> instr_pointer == $past(instr_pointer) + 13'h0001;
  endproperty
  property p_ip_moment;
    $changed(instr_pointer) |-> phase inside {cpu_core_pkg::phase_1, cpu_core_pkg::phase_2};
  endproperty
  property p_exec_moment;
    $changed(exec_valid) |-> phase == cpu_core_pkg::phase_2;
  endproperty
  property p_flush;
    $fell(exec_valid) |-> !exec_valid [*4];
  endproperty
  property p_w_moment;
    $changed(working_accumulator) |-> phase == cpu_core_pkg::phase_1;
  endproperty
  property p_st_moment;
    $changed(status_out) |-> phase == cpu_core_pkg::phase_1 && status_out[4:3] == 2'h3;
  endproperty
  property p_clkout;
    rc_mode == $past(rc_mode) |->
      clock_output_pin == (rc_mode && phase inside {cpu_core_pkg::phase_3, cpu_core_pkg::phase_4});
  endproperty
  property p_clear_vals;
    disable iff (rst) !master_clear_n |=> phase == cpu_core_pkg::phase_1 && instr_pointer == 13'h0000
      && working_accumulator == 8'h00 && status_out == 8'h18 && !exec_valid;
  endproperty
  a_phase_seq: assert property (p_phase_seq) else $error("phase order broken");
  a_ip_step: assert property (p_ip_step) else $error("pointer did not step");
  a_ip_moment: assert property (p_ip_moment) else $error("pointer moved late");
  a_exec_moment: assert property (p_exec_moment) else $error("execute start misplaced");
  a_flush: assert property (p_flush) else $error("flush shorter than a cycle");
  a_w_moment: assert property (p_w_moment) else $error("accumulator written late");
  a_st_moment: assert property (p_st_moment) else $error("status written late");
  a_clkout: assert property (p_clkout) else $error("clock output wrong");
  a_clear_vals: assert property (p_clear_vals) else $error("clear left state");
  c_flush: cover property ($fell(exec_valid));
  c_clkout: cover property ($rose(clock_output_pin));
  c_zero: cover property ($rose(status_out[2]));
endmodule

bind cpu_core cpu_core_checker checker_i (
  .clock(clock),
  .rst(rst),
  .master_clear_n(master_clear_n),
  .rc_mode(rc_mode),
  .clock_output_pin(clock_output_pin),
  .instr_pointer(instr_pointer),
  .phase(phase),
  .working_accumulator(working_accumulator),
  .status_out(status_out),
  .exec_valid(exec_valid)
);
`default_nettype wire

// ### verification/pmem_loader.sv
// Program memory side: writes a program image into the core word by word.
// Assumes the core takes one word on each edge while the load strobe is high.
`timescale 1ns/10ps
`default_nettype none

module pmem_loader (
  input wire logic clock,
  input wire logic start,
  input wire logic [31:0][13:0] image,
  output logic pmem_load_en,
  output logic [9:0] pmem_load_addr,
  output logic [13:0] pmem_load_data,
  output logic done
);
  logic [5:0] idx = 6'h00;
  assign done = idx[5];
  initial begin
    pmem_load_en = 1'b0;
    pmem_load_addr = 10'h000;
    pmem_load_data = 14'h0000;
  end
  // Idle data toggles so a stale word never looks like a valid write.
  always @(negedge clock) begin
    if (start && !idx[5]) begin
      pmem_load_en <= 1'b1;
      pmem_load_addr <= {5'h00, idx[4:0]};
      pmem_load_data <= image[idx[4:0]];
      idx <= idx + 6'h01;
    end else begin
      pmem_load_en <= 1'b0;
      pmem_load_data <= ~pmem_load_data;
    end
  end
endmodule
`default_nettype wire

// ### verification/cpu_core_tb.sv
// Self-checking bench for the core sequencing block.
// Assumes the loader fills program memory while master clear is held.
`timescale 1ns/10ps
`default_nettype none

module cpu_core_tb;
  typedef struct packed {
    logic [13:0] op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] w;
    logic [2:0] f;
  } row_s;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic master_clear_n = 1'b0;
  logic rc_mode = 1'b1;
  logic irq_request = 1'b0;
  logic start = 1'b1;
  logic done, pmem_load_en, clock_output_pin, exec_valid;
  logic [9:0] pmem_load_addr;
  logic [13:0] pmem_load_data;
  logic [31:0][13:0] image;
  logic [12:0] instr_pointer;
  cpu_core_pkg::phase_e phase;
  logic [7:0] working_accumulator;
  logic [7:0] status_out;
  int n_errors = 0;
  int checks = 0;
  int k;
  row_s rows [7];

  always #2.5 clock = ~clock;

  pmem_loader loader (.clock(clock), .start(start), .image(image), .pmem_load_en(pmem_load_en),
    .pmem_load_addr(pmem_load_addr), .pmem_load_data(pmem_load_data), .done(done));

  cpu_core DUT (.clock(clock), .rst(rst), .master_clear_n(master_clear_n), .rc_mode(rc_mode),
    .irq_request(irq_request), .pmem_load_en(pmem_load_en), .pmem_load_addr(pmem_load_addr),
    .pmem_load_data(pmem_load_data), .clock_output_pin(clock_output_pin),
    .instr_pointer(instr_pointer), .phase(phase), .working_accumulator(working_accumulator),
    .status_out(status_out), .exec_valid(exec_valid));

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic count_high(input logic [12:0] exp);
    k = 0;
    repeat (8) begin
      @(negedge clock);
      if (clock_output_pin === 1'b1) k++;
    end
    chk(13'(k), exp);
  endtask

  task automatic results;
    $display("Checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    // Each row loads a into the accumulator, then applies op with literal b.
    rows = '{'{14'h3E00, 8'h0F, 8'h01, 8'h10, 3'h2}, '{14'h3E00, 8'hFF, 8'h01, 8'h00, 3'h7},
      '{14'h3C00, 8'h01, 8'h01, 8'h00, 3'h7}, '{14'h3C00, 8'h02, 8'h01, 8'hFF, 3'h0},
      '{14'h3900, 8'hF0, 8'h0F, 8'h00, 3'h4}, '{14'h3800, 8'h50, 8'h0A, 8'h5A, 3'h0},
      '{14'h3A00, 8'hAA, 8'hAA, 8'h00, 3'h4}};
    image = '0;
    for (int r = 0; r < 7; r++) begin
      image[2*r] = 14'h3000 | 14'(rows[r].a);
      image[2*r+1] = rows[r].op | 14'(rows[r].b);
    end
    // Jump over a word that must never execute, then a file round trip.
    image[14] = 14'h2810;
    image[15] = 14'h3077;
    image[16] = 14'h3033;
    image[17] = 14'h00A0;
    image[18] = 14'h0720;
    // Store through the file select register, then read the same file back directly.
    image[19] = 14'h3025;
    image[20] = 14'h0084;
    image[21] = 14'h303C;
    image[22] = 14'h0080;
    image[23] = 14'h0100;
    image[24] = 14'h0825;
    // A pointer-low write with the latch at 04h lands above 1K and must wrap to word 1Eh.
    image[25] = 14'h3004;
    image[26] = 14'h008A;
    image[27] = 14'h301E;
    image[28] = 14'h0082;
    image[29] = 14'h3099;
    image[30] = 14'h3041;
    image[31] = 14'h281F;
    cyc(3);
    rst = 1'b0;
    for (k = 0; k < 40 && done !== 1'b1; k++) cyc(1);
    cyc(1);
    chk(13'(phase), 13'h0000);
    master_clear_n = 1'b1;
    cyc(1);
    chk(instr_pointer, 13'h0001);
    chk(13'(phase), 13'h0001);
    cyc(11);
    foreach (rows[r]) begin
      chk(13'(working_accumulator), 13'(rows[r].w));
      chk(13'(status_out[2:0]), 13'(rows[r].f));
      cyc(8);
    end
    chk(13'(working_accumulator), 13'h0000);
    chk(13'(exec_valid), 13'h0000);
    cyc(4);
    chk(13'(working_accumulator), 13'h0033);
    cyc(8);
    chk(13'(working_accumulator), 13'h0066);
    chk(13'(status_out[2:0]), 13'h0000);
    cyc(24);
    chk(13'(working_accumulator), 13'h003C);
    chk(13'(status_out[2:0]), 13'h0000);
    cyc(16);
    chk(instr_pointer, 13'h041E);
    cyc(4);
    chk(13'(working_accumulator), 13'h001E);
    chk(13'(exec_valid), 13'h0000);
    cyc(4);
    chk(13'(working_accumulator), 13'h0041);
    $display("Pipeline and ALU tests done");
    count_high(13'h0004);
    rc_mode = 1'b0;
    cyc(2);
    count_high(13'h0000);
    $display("Clock output tests done");
    irq_request = 1'b1;
    cyc(1);
    irq_request = 1'b0;
    for (k = 0; k < 16 && instr_pointer !== 13'h0004; k++) cyc(1);
    chk(instr_pointer, 13'h0004);
    $display("Interrupt test done");
    master_clear_n = 1'b0;
    cyc(1);
    chk(13'(phase), 13'h0000);
    chk(instr_pointer, 13'h0000);
    chk(13'(working_accumulator), 13'h0000);
    chk(13'(status_out), 13'h0018);
    chk(13'(exec_valid), 13'h0000);
    master_clear_n = 1'b1;
    cyc(12);
    chk(13'(working_accumulator), 13'h0010);
    $display("Clear test done");
    results();
  end

  // The tests need about 210 cycles; 2000 cycles means a hang.
  initial begin
    #10000;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
